// file: inc/tpir_pkg.sv
// shared constants, types and helpers of the touch probe input routing block
// assumes one 100 MHz clock and an avalon-mm slave port with 32-bit data
package tpir_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NPIN = 3;
    localparam int NCH = 3;
    localparam int NAX = 3;
    localparam int NEDGE = 2;
    localparam int NWORD = NCH * NAX * NEDGE;
    localparam int WIDX_W = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLT_SEL_W = 2;
    localparam int FLT_CNT_W = 7;

    // ************************************************************
    // device codes and axis-select encodings
    // ************************************************************
    localparam logic [7:0] DEV_PROBE_ONE = 8'h2C;
    localparam logic [7:0] DEV_PROBE_TWO = 8'h2D;
    localparam logic [7:0] DEV_PROBE_THREE = 8'h63;
    localparam logic [7:0] DEV_NONE = 8'h62;
    localparam logic [NCH-1:0][7:0] CH_CODE = {DEV_PROBE_THREE, DEV_PROBE_TWO, DEV_PROBE_ONE};
    localparam logic [2:0] AXSEL_AUTO = 3'h0;
    localparam logic [2:0] AXSEL_B = 3'h2;
    localparam logic [2:0] AXSEL_BC = 3'h6;
    localparam logic [2:0] AXSEL_ABC = 3'h7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [NPIN-1:0][7:0] DEV_RESET = {DEV_NONE, DEV_PROBE_TWO, DEV_PROBE_ONE};
    localparam logic [2:0] AXSEL_RESET = AXSEL_AUTO;
    localparam logic LATCH_SEL_RESET = 1'b0;
    localparam logic [FLT_SEL_W-1:0] FLT_SEL_RESET = 2'h0;

    // ************************************************************
    // register map (byte addresses) and field layout
    // ************************************************************
    localparam logic [NPIN-1:0][ADDR_W-1:0] OFS_PIN_CFG = {8'h08, 8'h04, 8'h00};
    localparam logic [ADDR_W-1:0] OFS_FILTER = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ZERO_AXIS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_LATCH_SEL = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_RESULT_END = 8'h88;
    localparam int CFG_DEV_LSB = 0;
    localparam int CFG_AX_LSB = 8;
    localparam int CTRL_STRIDE = 8;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ZERO_BIT = 2;
    localparam int CTRL_RISE_BIT = 4;
    localparam int CTRL_FALL_BIT = 5;
    localparam logic [7:0] CTRL_BYTE_MASK = 8'h35;
    localparam int ZAX_W = 2;
    localparam int LEVEL_BYP_LSB = 4;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int FLT_TICK_NS = 1000;
    localparam int FLT_TICK_CYC = (FLT_TICK_NS / CLK_PERIOD_NS < 1) ? 1 : FLT_TICK_NS / CLK_PERIOD_NS;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } tpir_avm_req_s;

    typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_DONE} tpir_bus_e;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [WIDX_W-1:0] tpir_word_index(input int ch, input int ax, input int edg);
        tpir_word_index = WIDX_W'(ch * NAX * NEDGE + ax * NEDGE + edg);
    endfunction

    function automatic int tpir_word_axis(input int idx);
        tpir_word_axis = (idx / NEDGE) % NAX;
    endfunction

    function automatic logic [DATA_W-1:0] tpir_merge_be(input logic [DATA_W-1:0] cur,
                                                       input logic [DATA_W-1:0] nw, input logic [3:0] be);
        logic [DATA_W-1:0] res;
        res = cur;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        tpir_merge_be = res;
    endfunction

    function automatic logic tpir_is_probe_code(input logic [7:0] code);
        tpir_is_probe_code = (code == DEV_PROBE_ONE) || (code == DEV_PROBE_TWO) || (code == DEV_PROBE_THREE);
    endfunction

endpackage

// file: logic/tpir_input_filter.sv
// selectable noise filter on the assignable input pins
// assumes pin inputs are already synchronous to sys_clk
module tpir_input_filter (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [tpir_pkg::NPIN-1:0] pin_raw,
    input wire logic [tpir_pkg::NPIN-1:0] bypass,
    input wire logic [tpir_pkg::FLT_SEL_W-1:0] flt_sel,
    output logic [tpir_pkg::NPIN-1:0] pin_out
);
    import tpir_pkg::*;

    // ************************************************************
    // sample tick divider
    // ************************************************************
    logic [FLT_CNT_W-1:0] div_q;
    logic tick_q;
    logic [NPIN-1:0] out_q;
    logic [NPIN-1:0][FLT_SEL_W-1:0] cnt_q;

    wire div_wrap = (div_q == FLT_CNT_W'(FLT_TICK_CYC - 1));

    // one-cycle enable every filter sample period
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + FLT_CNT_W'(1);
            tick_q <= div_wrap;
        end
    end

    // ************************************************************
    // per-pin stability counter
    // ************************************************************
    // a level must differ for flt_sel consecutive samples before it passes
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        wire pass_now = bypass[p] || (flt_sel == '0);  // probe pins skip the filter
        wire differs = (pin_raw[p] != out_q[p]);
        wire settled = (cnt_q[p] + FLT_SEL_W'(1)) >= flt_sel;
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                out_q[p] <= 1'b0;
                cnt_q[p] <= '0;
            end else if (pass_now) begin
                out_q[p] <= pin_raw[p];
                cnt_q[p] <= '0;
            end else if (!differs) begin
                cnt_q[p] <= '0;
            end else if (tick_q) begin
                out_q[p] <= settled ? pin_raw[p] : out_q[p];
                cnt_q[p] <= settled ? '0 : cnt_q[p] + FLT_SEL_W'(1);
            end
        end
    end

    assign pin_out = out_q;

endmodule

// file: logic/tpir_latch_mem.sv
// result storage for latched positions, one word per channel, axis and edge
// assumes writes of several words may land in one cycle; read data is registered
module tpir_latch_mem (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [tpir_pkg::NWORD-1:0] wen,
    input wire logic [tpir_pkg::NAX-1:0][tpir_pkg::DATA_W-1:0] axis_data,
    input wire logic [tpir_pkg::WIDX_W-1:0] raddr,
    output logic [tpir_pkg::DATA_W-1:0] rdata
);
    import tpir_pkg::*;

    // ************************************************************
    // storage
    // ************************************************************
    logic [NWORD-1:0][DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] rdata_q;

    // every word takes its own axis value, so one edge can fill several words at once
    for (genvar i = 0; i < NWORD; i++) begin : g_word
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                mem_q[i] <= '0;
            end else if (wen[i]) begin
                mem_q[i] <= axis_data[tpir_word_axis(i)];
            end
        end
    end

    // registered read port, out-of-range reads give zero
    wire [DATA_W-1:0] rd_word = (raddr < WIDX_W'(NWORD)) ? mem_q[raddr] : '0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_word;
        end
    end

    assign rdata = rdata_q;

endmodule

// file: logic/tpir_top.sv
// touch probe input routing: assignable pins to three probe channels on three axes
// assumes an avalon-mm master with waitrequest and positions valid every cycle
module tpir_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire tpir_pkg::tpir_avm_req_s avm_req,
    output logic avm_waitrequest,
    output logic [tpir_pkg::DATA_W-1:0] avm_readdata,
    input wire logic [tpir_pkg::NPIN-1:0] pin_raw,
    input wire logic [tpir_pkg::NAX-1:0] zero_mark,
    input wire logic [tpir_pkg::NAX-1:0][tpir_pkg::DATA_W-1:0] pos_fb,
    input wire logic [tpir_pkg::NAX-1:0][tpir_pkg::DATA_W-1:0] pos_cmd,
    output logic [tpir_pkg::NCH-1:0] probe_event,
    output logic [tpir_pkg::NPIN-1:0] pin_level
);
    import tpir_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    tpir_bus_e bus_q;
    logic wait_q;
    logic [DATA_W-1:0] rdata_q;
    logic [NPIN-1:0][7:0] dev_q;
    logic [NPIN-1:0][2:0] axsel_q;
    logic [FLT_SEL_W-1:0] flt_sel_q;
    logic [NCH-1:0][7:0] ctrl_q;
    logic [NCH-1:0][ZAX_W-1:0] zax_q;
    logic latch_sel_q;
    logic [NWORD-1:0] stat_q;
    logic [NWORD-1:0] stat_d;
    logic [NPIN-1:0] prev_q;
    logic [NCH-1:0] event_q;
    logic [NPIN-1:0] level_q;
    logic [NPIN-1:0] pin_filt;
    logic [NPIN-1:0] bypass;
    logic [NWORD-1:0] wen;
    logic [NAX-1:0][DATA_W-1:0] axis_data;
    logic [DATA_W-1:0] mem_rdata;

    // ************************************************************
    // helpers
    // ************************************************************
    // axis mask actually used by a pin; auto resolves to the owning axis
    function automatic logic [NAX-1:0] eff_mask(input logic [2:0] sel, input int own);
        logic [NAX-1:0] m;
        m = '0;
        m[own] = 1'b1;
        eff_mask = (sel == AXSEL_AUTO) ? m : sel;
    endfunction

    function automatic logic [DATA_W-1:0] pin_cfg_word(input logic [7:0] dev, input logic [2:0] ax);
        logic [DATA_W-1:0] w;
        w = '0;
        w[CFG_DEV_LSB +: 8] = dev;
        w[CFG_AX_LSB +: 3] = ax;
        pin_cfg_word = w;
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    wire [ADDR_W-1:0] addr = avm_req.address;
    wire aligned = (addr[1:0] == 2'b00);
    wire hit_filter = aligned && (addr == OFS_FILTER);
    wire hit_ctrl = aligned && (addr == OFS_CTRL);
    wire hit_zax = aligned && (addr == OFS_ZERO_AXIS);
    wire hit_lsel = aligned && (addr == OFS_LATCH_SEL);
    wire hit_stat = aligned && (addr == OFS_STATUS);
    wire hit_level = aligned && (addr == OFS_LEVEL);
    wire hit_result = aligned && (addr >= OFS_RESULT) && (addr < OFS_RESULT_END);
    wire [ADDR_W-1:0] res_off = addr - OFS_RESULT;
    wire [WIDX_W-1:0] mem_raddr = res_off[WIDX_W+1:2];
    wire wr_fire = (bus_q == BUS_DONE) && avm_req.write;
    wire [DATA_W-1:0] wdata = avm_req.writedata;
    wire [3:0] be = avm_req.byteenable;

    logic [NPIN-1:0] hit_pin;
    logic [NPIN-1:0][DATA_W-1:0] pin_word;
    for (genvar p = 0; p < NPIN; p++) begin : g_dec
        assign hit_pin[p] = (addr == OFS_PIN_CFG[p]);
        assign pin_word[p] = pin_cfg_word(dev_q[p], axsel_q[p]);
    end

    wire [DATA_W-1:0] ctrl_word = {8'h00, ctrl_q[2] & CTRL_BYTE_MASK, ctrl_q[1] & CTRL_BYTE_MASK,
                                   ctrl_q[0] & CTRL_BYTE_MASK};
    wire [DATA_W-1:0] level_word = DATA_W'({bypass, 1'b0, pin_filt});
    wire [DATA_W-1:0] pin_sel_word = hit_pin[0] ? pin_word[0] : hit_pin[1] ? pin_word[1] :
                                     hit_pin[2] ? pin_word[2] : '0;

    // read mux; unmapped addresses read zero and ignore writes
    wire [DATA_W-1:0] rd_mux = (|hit_pin) ? pin_sel_word :
                               hit_filter ? DATA_W'(flt_sel_q) :
                               hit_ctrl ? ctrl_word :
                               hit_zax ? DATA_W'(zax_q) :
                               hit_lsel ? DATA_W'(latch_sel_q) :
                               hit_stat ? DATA_W'(stat_q) :
                               hit_level ? level_word :
                               hit_result ? mem_rdata : '0;

    // ************************************************************
    // bus handshake
    // ************************************************************
    // three cycles per access: decode, fetch from registered memory, answer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_q <= BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    bus_q <= (avm_req.read || avm_req.write) ? BUS_FETCH : BUS_IDLE;
                end
                BUS_FETCH: begin
                    rdata_q <= avm_req.read ? rd_mux : rdata_q;
                    wait_q <= 1'b0;
                    bus_q <= BUS_DONE;
                end
                BUS_DONE: begin
                    wait_q <= 1'b1;
                    bus_q <= BUS_IDLE;
                end
                default: begin
                    wait_q <= 1'b1;
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // per-pin device code and axis mask, written through byte lanes
    for (genvar p = 0; p < NPIN; p++) begin : g_cfg
        wire [DATA_W-1:0] merged = tpir_merge_be(pin_word[p], wdata, be);
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                dev_q[p] <= DEV_RESET[p];
                axsel_q[p] <= AXSEL_RESET;
            end else if (wr_fire && hit_pin[p]) begin
                dev_q[p] <= merged[CFG_DEV_LSB +: 8];
                axsel_q[p] <= merged[CFG_AX_LSB +: 3];
            end
        end
    end

    wire [DATA_W-1:0] ctrl_merged = tpir_merge_be(ctrl_word, wdata, be);
    wire [DATA_W-1:0] misc_cur = hit_filter ? DATA_W'(flt_sel_q) : hit_zax ? DATA_W'(zax_q) :
                                 DATA_W'(latch_sel_q);
    wire [DATA_W-1:0] misc_merged = tpir_merge_be(misc_cur, wdata, be);

    // channel control, zero-point axis, filter and latch-position selection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '0;
            zax_q <= '0;
            flt_sel_q <= FLT_SEL_RESET;
            latch_sel_q <= LATCH_SEL_RESET;
        end else if (wr_fire) begin
            ctrl_q <= hit_ctrl ? ctrl_merged[NCH*CTRL_STRIDE-1:0] : ctrl_q;
            zax_q <= hit_zax ? misc_merged[NCH*ZAX_W-1:0] : zax_q;
            flt_sel_q <= hit_filter ? misc_merged[FLT_SEL_W-1:0] : flt_sel_q;
            latch_sel_q <= hit_lsel ? misc_merged[0] : latch_sel_q;
        end
    end

    // ************************************************************
    // pin filtering and edge detection
    // ************************************************************
    for (genvar p = 0; p < NPIN; p++) begin : g_byp
        assign bypass[p] = tpir_is_probe_code(dev_q[p]);
    end

    tpir_input_filter u_filter (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_raw(pin_raw),
        .bypass(bypass),
        .flt_sel(flt_sel_q),
        .pin_out(pin_filt)
    );

    // previous level starts low, so a pin already high at reset shows one rise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= pin_filt;
        end
    end

    wire [NPIN-1:0] pin_rise = pin_filt & ~prev_q;
    wire [NPIN-1:0] pin_fall = ~pin_filt & prev_q;

    // ************************************************************
    // routing of pins to channel and axis
    // ************************************************************
    // every channel/axis pair looks at all pins, so any mix of pins may feed it
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        wire ch_en = ctrl_q[c][CTRL_EN_BIT];
        wire zero_mode = ctrl_q[c][CTRL_ZERO_BIT];
        wire rise_en = ctrl_q[c][CTRL_RISE_BIT];
        wire fall_en = ctrl_q[c][CTRL_FALL_BIT];
        for (genvar a = 0; a < NAX; a++) begin : g_ax
            logic [NPIN-1:0] route;
            for (genvar p = 0; p < NPIN; p++) begin : g_pin
                // code picks the channel, mask picks the axes
                wire [NAX-1:0] pmask = eff_mask(axsel_q[p], p);
                assign route[p] = (dev_q[p] == CH_CODE[c]) && pmask[a];
            end
            // zero-point mode ignores pins and serves only the configured axis
            wire zero_hit = (zax_q[c] == ZAX_W'(a)) && zero_mark[a];
            wire trig_rise = zero_mode ? zero_hit : |(route & pin_rise);
            wire trig_fall = zero_mode ? 1'b0 : |(route & pin_fall);
            assign wen[tpir_word_index(c, a, 0)] = ch_en && rise_en && trig_rise;
            assign wen[tpir_word_index(c, a, 1)] = ch_en && fall_en && trig_fall;
        end
    end

    // all enabled axes sample their position in the same cycle
    for (genvar a = 0; a < NAX; a++) begin : g_pos
        assign axis_data[a] = latch_sel_q ? pos_cmd[a] : pos_fb[a];
    end

    tpir_latch_mem u_mem (
        .sys_clk(sys_clk),
        .rst(rst),
        .wen(wen),
        .axis_data(axis_data),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ************************************************************
    // status and event outputs
    // ************************************************************
    // write-one-to-clear; a capture in the clearing cycle keeps its bit set
    wire [NWORD-1:0] stat_clr = (wr_fire && hit_stat) ? wdata[NWORD-1:0] : '0;
    assign stat_d = (stat_q & ~stat_clr) | wen;

    logic [NCH-1:0] ch_event;
    for (genvar c = 0; c < NCH; c++) begin : g_ev
        assign ch_event[c] = |wen[c*NAX*NEDGE +: NAX*NEDGE];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
            event_q <= '0;
            level_q <= '0;
        end else begin
            stat_q <= stat_d;
            event_q <= ch_event;
            level_q <= pin_filt;
        end
    end

    assign avm_waitrequest = wait_q;
    assign avm_readdata = rdata_q;
    assign probe_event = event_q;
    assign pin_level = level_q;

endmodule

// file: logic/tpir_end.sv
// ************************************************************
// intentionally empty compile unit marker
// ************************************************************

// file: test/tpir_props.sv
// port checker for the touch probe input routing top
// assumes a single clock domain; bound to every tpir_top instance below
module tpir_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire tpir_pkg::tpir_avm_req_s avm_req,
    input wire logic avm_waitrequest,
    input wire logic [tpir_pkg::DATA_W-1:0] avm_readdata,
    input wire logic [tpir_pkg::NAX-1:0] zero_mark,
    input wire logic [tpir_pkg::NPIN-1:0] pin_raw,
    input wire logic [tpir_pkg::NCH-1:0] probe_event,
    input wire logic [tpir_pkg::NPIN-1:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    import tpir_pkg::*;
    logic [1:0] age_q;
    logic touched_q;
    logic [2:0] zq_q;
    // decoded bus views
    wire logic req_any = avm_req.read | avm_req.write;
    wire logic rd_ans = avm_req.read & ~avm_waitrequest;
    wire logic a_hole = (avm_req.address[1:0] != 2'h0) || avm_req.address >= OFS_RESULT_END
        || (avm_req.address > OFS_LEVEL && avm_req.address < OFS_RESULT);
    // settle age, pin config touched, zero pulse history (zero path latency is one cycle)
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            age_q <= 2'h0;
            touched_q <= 1'b0;
            zq_q <= 3'h0;
        end else begin
            age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
            touched_q <= touched_q | (avm_req.write & (avm_req.address < OFS_FILTER));
            zq_q <= {zq_q[1:0], |zero_mark};
        end
    end
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    AST_ANSWER_TWO: assert property ($rose(req_any) |->
        avm_waitrequest ##1 avm_waitrequest ##1 !avm_waitrequest)
        else $error("bus answer not in third cycle");
    AST_IDLE_WAIT: assert property (!req_any |-> avm_waitrequest)
        else $error("waitrequest low without request");
    AST_RDATA_HOLD: assert property (avm_readdata != $past(avm_readdata) |-> rd_ans)
        else $error("read data moved outside a read answer");
    AST_HOLE_ZERO: assert property (rd_ans && a_hole |-> avm_readdata == '0)
        else $error("unmapped read not zero");
    AST_CFG_RSVD: assert property (rd_ans && avm_req.address < OFS_FILTER |-> avm_readdata[31:11] == '0)
        else $error("pin config spare bits set");
    AST_LATCH_RSVD: assert property (rd_ans && avm_req.address == OFS_LATCH_SEL |-> avm_readdata[31:1] == '0)
        else $error("latch select spare bits set");
    AST_EVENT_CAUSE: assert property (probe_event != '0 && zq_q == 3'h0 |-> pin_level != $past(pin_level))
        else $error("probe event without pin edge");
    AST_BYPASS_DEFAULT: assert property (age_q == 2'h3 && !touched_q |->
        pin_level[1:0] == $past(pin_raw[1:0], 2))
        else $error("default probe pins delayed by filter");
    CVR_PIN_EVENT: cover property (probe_event != '0 && zq_q == 3'h0);
    CVR_ZERO_EVENT: cover property (probe_event != '0 && zq_q != 3'h0);
    CVR_HOLE_READ: cover property (rd_ans && a_hole);
endmodule

bind tpir_top tpir_checker i_chk (.sys_clk, .rst, .avm_req, .avm_waitrequest, .avm_readdata, .zero_mark,
    .pin_raw, .probe_event, .pin_level);

// file: test/tpir_sensor_model.sv
// model of the external trigger sensors wired to the assignable pins
// assumes the bench asks for pin levels through want; slow adds sensor lag
module tpir_sensor_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [tpir_pkg::NPIN-1:0] want,
    input wire logic slow,
    output logic [tpir_pkg::NPIN-1:0] pin_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    import tpir_pkg::*;
    logic [NPIN-1:0] lag_q [3];
    // push-pull outputs follow one cycle or four cycles late, like a sluggish switch
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lag_q <= '{default: '0};
            pin_raw <= '0;
        end else begin
            lag_q <= '{want, lag_q[0], lag_q[1]};
            pin_raw <= slow ? lag_q[2] : want;
        end
    end
endmodule

// file: test/tpir_bench.sv
// self-checking bench for the touch probe input routing top
// assumes the sensor model drives the pins and this module is the bus master
module tpir_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tpir_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    tpir_avm_req_s avm_req = '0;
    logic avm_waitrequest;
    logic [DATA_W-1:0] avm_readdata;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] want = '0;
    logic slow = 1'b0;
    logic [NAX-1:0] zero_mark = '0;
    logic [NAX-1:0][DATA_W-1:0] pos_fb = {32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
    logic [NAX-1:0][DATA_W-1:0] pos_cmd = {32'hCCCC_CCCC, 32'hBBBB_BBBB, 32'hAAAA_AAAA};
    logic [NCH-1:0] probe_event;
    logic [NPIN-1:0] pin_level;
    logic [DATA_W-1:0] q;
    int num_errors = 0;
    int checks = 0;
    // routing table: pin, device code, axis mask, status, result word
    int t_pin [6] = '{0, 0, 1, 2, 2, 1};
    logic [7:0] t_cd [6] = '{8'h2C, 8'h2C, 8'h2C, 8'h2D, 8'h63, 8'h62};
    logic [2:0] t_ax [6] = '{3'h0, 3'h2, 3'h6, 3'h7, 3'h0, 3'h0};
    logic [31:0] t_st [6] = '{32'h1, 32'h4, 32'h14, 32'h540, 32'h1_0000, 32'h0};
    int t_wd [6] = '{0, 2, 2, 6, 16, 0};
    logic [2:0] t_ev [6] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h4, 3'h0};

    tpir_top i_dut (.sys_clk, .rst, .avm_req, .avm_waitrequest, .avm_readdata, .pin_raw, .zero_mark,
        .pos_fb, .pos_cmd, .probe_event, .pin_level);
    tpir_sensor_model i_sensor (.sys_clk, .rst, .want, .slow, .pin_raw);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // one bus access; an edge passes first so a release is never overwritten in its own step
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avm_req.address <= a;
        avm_req.read <= ~wr;
        avm_req.write <= wr;
        avm_req.writedata <= d;
        avm_req.byteenable <= 4'hF;
        do @(posedge sys_clk); while (avm_waitrequest !== 1'b0);
        q = avm_readdata;
        avm_req.read <= 1'b0;
        avm_req.write <= 1'b0;
    endtask

    // single compare point: value seen against value expected
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(n, q, e);
    endtask

    // toggle one pin through the sensor and wait until it shows
    task automatic fire(input int p, input logic s);
        @(posedge sys_clk);
        slow <= s;
        want[p] <= ~want[p];
        do @(posedge sys_clk); while (pin_raw[p] !== want[p]);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd("pin0 cfg", OFS_PIN_CFG[0], 32'h2C);
        rd("pin1 cfg", OFS_PIN_CFG[1], 32'h2D);
        rd("latch sel", OFS_LATCH_SEL, 32'h0);
        rd("hole", 8'h24, 32'h0);
        rd("unaligned", 8'h02, 32'h0);
        acc(1'b1, OFS_FILTER, 32'h3);
        fire(0, 1'b0);
        rd("level", OFS_LEVEL, 32'h31);
        fire(0, 1'b1);
        $display("reset and filter test done");
        acc(1'b1, OFS_CTRL, 32'h0011_1111);
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, OFS_STATUS, 32'h3_FFFF);
            acc(1'b1, OFS_PIN_CFG[t_pin[i]], {21'h0, t_ax[i], t_cd[i]});
            fire(t_pin[i], i[0]);
            // event pulse and filtered level stand two edges after the pin is first seen
            repeat (2) @(posedge sys_clk);
            chk("event", 32'(probe_event), 32'(t_ev[i]));
            chk("pin level", 32'(pin_level[t_pin[i]]), 32'(t_cd[i] != 8'h62));
            rd("status", OFS_STATUS, t_st[i]);
            rd("result", 8'h40 + 8'(4 * t_wd[i]), pos_fb[(t_wd[i] / 2) % 3]);
            fire(t_pin[i], 1'b0);
        end
        $display("routing test done");
        acc(1'b1, OFS_LATCH_SEL, 32'h1);
        acc(1'b1, OFS_PIN_CFG[0], 32'h22C);
        fire(0, 1'b0);
        rd("cmd result", 8'h48, pos_cmd[1]);
        fire(0, 1'b0);
        $display("latch select test done");
        acc(1'b1, OFS_PIN_CFG[0], 32'h72C);
        acc(1'b1, OFS_CTRL, 32'h0011_1115);
        acc(1'b1, OFS_ZERO_AXIS, 32'h1);
        acc(1'b1, OFS_STATUS, 32'h3_FFFF);
        @(posedge sys_clk);
        zero_mark <= 3'h7;
        @(posedge sys_clk);
        zero_mark <= 3'h0;
        fire(0, 1'b0);
        rd("zero status", OFS_STATUS, 32'h4);
        $display("zero point test done");
        stop_test();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule
